// File: dcs_params.svh
// Constants for the dual channel safe stop monitor.
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH
`define DCS_CLK_HZ          20000000
`define DCS_SKEW_MS         100
`define DCS_CYC_PER_MS      (`DCS_CLK_HZ / 1000)
`define DCS_SEL_SAFE_STOP   6'h21
`define DCS_SEL_MISMATCH    6'h22
`define DCS_SEL_ANY_FAULT   6'h0D
`define DCS_SEL_NO_FAULT    6'h1A
`define DCS_STATE_READY     4'h0
`define DCS_STATE_RUN       4'h1
`define DCS_STATE_UNDERV    4'h2
`define DCS_STATE_FAULT     4'h3
`define DCS_STATE_TUNING    4'h4
`define DCS_STATE_CONFIG    4'h5
`define DCS_STATE_DC_BRAKE  4'h6
`define DCS_STATE_SAFE_STOP 4'h7
`endif

// File: dcs_pkg.sv
// Types for the dual channel safe stop monitor.
package dcs_pkg;
  typedef enum logic [1:0] {
    DCS_SAFE,
    DCS_SKEW,
    DCS_ENABLED
  } dcs_chan_e;
  typedef logic [5:0] dcs_sel_t;
endpackage : dcs_pkg

// File: dcs_safe_stop_monitor.sv
// Two channel safe stop monitor with drive state and indication outputs.
`include "dcs_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - Both channels low holds safe stop and ignores start and run commands; fault reset still clears a latched mismatch.
// - Safe stop releases only when both channels are high together.
// - One channel high, other low trips the channel mismatch fault.
// - Mismatch fault stays latched until a drive fault reset.
// - Both channels high disables safe stop and commands are accepted.
// - Channels must change within 100 ms, else mismatch fault.
// - Safe stop overrides run, ramps and every other control source except fault reset.
// - Drive state reported as one of eight states on a state port.
// - Output selection 33 shows safe stop active.
// - Output selection 34 shows channel mismatch fault.
// - Output selection 13 shows any fault present.
// - Output selection 26 shows no fault present.
// - After channels return, a start pulse is needed before running.
// - Three wire control: start on pulse, stop when stop input opens.
module dcs_safe_stop_monitor
  import dcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       safe_stop_channel_a,
  input  wire logic       safe_stop_channel_b,
  input  wire logic       start_pulse_input,
  input  wire logic       run_permit_input,
  input  wire logic       fault_reset,
  input  wire logic       other_fault,
  input  wire logic       undervoltage,
  input  wire logic       self_tuning,
  input  wire logic       configuring,
  input  wire logic       dc_braking,
  input  wire logic       ramp_done,
  input  wire logic [5:0] output1_function_select,
  input  wire logic [5:0] output2_function_select,
  input  wire logic [5:0] output3_function_select,
  input  wire logic [5:0] output4_function_select,
  input  wire logic [5:0] output5_function_select,
  output logic            safe_stop_active_state,
  output logic            channel_mismatch_fault,
  output logic            run_enable,
  output logic            ramp_down,
  output logic [3:0]      drive_state_param,
  output logic            indication_output_1,
  output logic            indication_output_2,
  output logic            indication_output_3,
  output logic            indication_output_4,
  output logic            indication_output_5
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [1:0] a_sync;
  logic [1:0] b_sync;
  logic [1:0] next_a_sync;
  logic [1:0] next_b_sync;

  always_comb begin
    next_a_sync = {a_sync[0], safe_stop_channel_a};
    next_b_sync = {b_sync[0], safe_stop_channel_b};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      a_sync <= 2'h0;
      b_sync <= 2'h0;
    end else begin
      a_sync <= next_a_sync;
      b_sync <= next_b_sync;
    end
  end

  logic chan_a;
  logic chan_b;
  assign chan_a = a_sync[1];
  assign chan_b = b_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Channel state machine, skew timer and latched mismatch fault.
  localparam logic [14:0] CYC_MS  = 15'(`DCS_CYC_PER_MS);
  localparam logic [6:0]  SKEW_MS = 7'(`DCS_SKEW_MS);

  dcs_chan_e   chan_state;
  dcs_chan_e   next_chan_state;
  logic [14:0] cyc_cnt;
  logic [14:0] next_cyc_cnt;
  logic [6:0]  ms_cnt;
  logic [6:0]  next_ms_cnt;
  logic        mismatch;
  logic        next_mismatch;

  always_comb begin
    next_chan_state = chan_state;
    next_cyc_cnt    = 15'h0000;
    next_ms_cnt     = 7'h00;
    next_mismatch   = mismatch;
    case (chan_state)
      DCS_SAFE: begin
        if (chan_a && chan_b) begin
          next_chan_state = DCS_ENABLED;
        end else if (chan_a != chan_b) begin
          next_chan_state = DCS_SKEW;
        end
      end
      DCS_ENABLED: begin
        if (!chan_a && !chan_b) begin
          next_chan_state = DCS_SAFE;
        end else if (chan_a != chan_b) begin
          next_chan_state = DCS_SKEW;
        end
      end
      DCS_SKEW: begin
        if (chan_a == chan_b) begin
          next_chan_state = chan_a ? DCS_ENABLED : DCS_SAFE;
        end else if (cyc_cnt == CYC_MS - 15'h0001) begin
          next_ms_cnt = ms_cnt + 7'h01;
        end else begin
          next_cyc_cnt = cyc_cnt + 15'h0001;
          next_ms_cnt  = ms_cnt;
        end
        if (chan_a != chan_b && ms_cnt >= SKEW_MS) begin
          next_mismatch = 1'b1;
        end
        if (ms_cnt >= SKEW_MS) begin
          next_ms_cnt = ms_cnt;
        end
      end
      default: begin
        next_chan_state = DCS_SAFE;
      end
    endcase
    if (fault_reset && !(chan_state == DCS_SKEW && ms_cnt >= SKEW_MS)) begin
      next_mismatch = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chan_state <= DCS_SAFE;
      cyc_cnt    <= 15'h0000;
      ms_cnt     <= 7'h00;
      mismatch   <= 1'b0;
    end else begin
      chan_state <= next_chan_state;
      cyc_cnt    <= next_cyc_cnt;
      ms_cnt     <= next_ms_cnt;
      mismatch   <= next_mismatch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three wire run control gated by safe stop.
  logic any_fault;
  logic safe_hold;
  logic running;
  logic next_running;

  // Safe stop stays held while channels disagree within the skew window.
  assign safe_hold = (chan_state != DCS_ENABLED);
  assign any_fault = mismatch | other_fault;

  always_comb begin
    next_running = running;
    if (safe_hold || any_fault || undervoltage) begin
      next_running = 1'b0;
    end else if (!run_permit_input) begin
      next_running = 1'b0;
    end else if (start_pulse_input) begin
      next_running = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      running <= 1'b0;
    end else begin
      running <= next_running;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State reporting and indication outputs.
  function automatic logic ind_sel(input dcs_sel_t sel, input logic act,
                                   input logic mis, input logic flt);
    case (sel)
      `DCS_SEL_SAFE_STOP: ind_sel = act;
      `DCS_SEL_MISMATCH:  ind_sel = mis;
      `DCS_SEL_ANY_FAULT: ind_sel = flt;
      `DCS_SEL_NO_FAULT:  ind_sel = !flt;
      default:            ind_sel = 1'b0;
    endcase
  endfunction : ind_sel

  logic [3:0] next_state_param;
  logic [4:0] ind;
  logic [4:0] next_ind;
  logic       ramp;
  logic       next_ramp;

  always_comb begin
    if (any_fault) begin
      next_state_param = `DCS_STATE_FAULT;
    end else if (safe_hold) begin
      next_state_param = `DCS_STATE_SAFE_STOP;
    end else if (undervoltage) begin
      next_state_param = `DCS_STATE_UNDERV;
    end else if (self_tuning) begin
      next_state_param = `DCS_STATE_TUNING;
    end else if (configuring) begin
      next_state_param = `DCS_STATE_CONFIG;
    end else if (dc_braking) begin
      next_state_param = `DCS_STATE_DC_BRAKE;
    end else if (running) begin
      next_state_param = `DCS_STATE_RUN;
    end else begin
      next_state_param = `DCS_STATE_READY;
    end
    next_ind[0] = ind_sel(output1_function_select, safe_hold, mismatch, any_fault);
    next_ind[1] = ind_sel(output2_function_select, safe_hold, mismatch, any_fault);
    next_ind[2] = ind_sel(output3_function_select, safe_hold, mismatch, any_fault);
    next_ind[3] = ind_sel(output4_function_select, safe_hold, mismatch, any_fault);
    next_ind[4] = ind_sel(output5_function_select, safe_hold, mismatch, any_fault);
    // Ramp down only while enabled and permit removed; safe stop cuts it.
    next_ramp = !safe_hold && !any_fault && !run_permit_input && !ramp_done
                && (running || ramp);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_state_param <= `DCS_STATE_SAFE_STOP;
      ind               <= 5'h00;
      ramp              <= 1'b0;
    end else begin
      drive_state_param <= next_state_param;
      ind               <= next_ind;
      ramp              <= next_ramp;
    end
  end

  assign safe_stop_active_state = safe_hold;
  assign channel_mismatch_fault = mismatch;
  assign run_enable             = running;
  assign ramp_down              = ramp;
  assign indication_output_1    = ind[0];
  assign indication_output_2    = ind[1];
  assign indication_output_3    = ind[2];
  assign indication_output_4    = ind[3];
  assign indication_output_5    = ind[4];

endmodule : dcs_safe_stop_monitor

// File: dcs_relay.sv
// Behavioural safety relay and control wiring ahead of the monitor.
module dcs_relay (
  input  wire logic clk,
  output logic      safe_stop_channel_a,
  output logic      safe_stop_channel_b,
  output logic      run_permit_input,
  output logic      start_pulse_input
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {safe_stop_channel_a, safe_stop_channel_b, run_permit_input, start_pulse_input} = 4'h0;
  task automatic set_ch(input logic a, input logic b, input int n);
    repeat (n) @(negedge clk);
    {safe_stop_channel_a, safe_stop_channel_b} = {a, b};
  endtask : set_ch
  task automatic pulse_start();
    @(negedge clk);
    start_pulse_input = 1'b1;
    @(negedge clk);
    start_pulse_input = 1'b0;
  endtask : pulse_start
  // Permit goes first so the drive ramps; channels drop after the stop time.
  task automatic ramp_stop();
    @(negedge clk);
    run_permit_input = 1'b0;
    set_ch(1'b0, 1'b1, 20);
    set_ch(1'b0, 1'b0, 30);
  endtask : ramp_stop
  task automatic restart(input int skew);
    set_ch(1'b1, safe_stop_channel_b, 1);
    set_ch(1'b1, 1'b1, skew);
    run_permit_input = 1'b1;
    repeat (4) @(negedge clk);
    pulse_start();
  endtask : restart
endmodule : dcs_relay

// File: dcs_chk_checker.sv
// Port checks for the safe stop monitor.
module dcs_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       safe_stop_channel_a,
  input wire logic       safe_stop_channel_b,
  input wire logic       start_pulse_input,
  input wire logic       run_permit_input,
  input wire logic       fault_reset,
  input wire logic [5:0] output1_function_select,
  input wire logic       safe_stop_active_state,
  input wire logic       channel_mismatch_fault,
  input wire logic       run_enable,
  input wire logic       indication_output_1
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_low;
    (!safe_stop_channel_a && !safe_stop_channel_b) [*4];
  endsequence
  sequence s_high;
    $past(safe_stop_channel_a, 3) && $past(safe_stop_channel_b, 3);
  endsequence
  AST_BOTH_LOW: assert property (s_low |-> safe_stop_active_state)
    else $error("safe stop not held");
  AST_RELEASE: assert property ($fell(safe_stop_active_state) |-> s_high)
    else $error("early release");
  AST_HOLD: assert property (safe_stop_active_state |=> !run_enable)
    else $error("run in safe stop");
  AST_MIS_SET: assert property ($rose(channel_mismatch_fault) |->
    $past(safe_stop_channel_a, 3) != $past(safe_stop_channel_b, 3))
    else $error("fault without disagreement");
  AST_LATCH: assert property (channel_mismatch_fault && !fault_reset |=>
    channel_mismatch_fault) else $error("fault lost");
  AST_START: assert property ($rose(run_enable) |-> $past(start_pulse_input))
    else $error("run without start");
  AST_STOP: assert property (!run_permit_input |=> !run_enable)
    else $error("run without permit");
  AST_IND: assert property (output1_function_select == 6'h21 |=>
    indication_output_1 == $past(safe_stop_active_state)) else $error("bad indication");
endmodule : dcs_chk
bind dcs_safe_stop_monitor dcs_chk dcs_chk_i (.clk, .rst, .safe_stop_channel_a,
  .safe_stop_channel_b, .start_pulse_input, .run_permit_input, .fault_reset,
  .output1_function_select, .safe_stop_active_state, .channel_mismatch_fault,
  .run_enable, .indication_output_1);

// File: testbench.sv
// Self-checking bench for the safe stop monitor.
`include "dcs_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst, fault_reset, other_fault, ramp_done, a, b, start, permit;
  logic       ss, mis, run, ramp;
  logic [3:0] st, state, exp_st;
  logic [5:0] sel [1:5];
  logic [5:1] ind;
  int         err_count, num_checks, cyc;
  dcs_relay dcs_relay_i (.clk, .safe_stop_channel_a(a), .safe_stop_channel_b(b),
    .run_permit_input(permit), .start_pulse_input(start));
  dcs_safe_stop_monitor dcs_safe_stop_monitor_i (.clk, .rst, .safe_stop_channel_a(a),
    .safe_stop_channel_b(b), .start_pulse_input(start), .run_permit_input(permit),
    .fault_reset, .other_fault, .undervoltage(st[3]), .self_tuning(st[2]),
    .configuring(st[1]), .dc_braking(st[0]), .ramp_done,
    .output1_function_select(sel[1]), .output2_function_select(sel[2]),
    .output3_function_select(sel[3]), .output4_function_select(sel[4]),
    .output5_function_select(sel[5]), .safe_stop_active_state(ss),
    .channel_mismatch_fault(mis), .run_enable(run), .ramp_down(ramp),
    .drive_state_param(state), .indication_output_1(ind[1]), .indication_output_2(ind[2]),
    .indication_output_3(ind[3]), .indication_output_4(ind[4]), .indication_output_5(ind[5]));
  task automatic chk(string n, logic [4:0] e, logic [4:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  initial begin
    {rst, fault_reset, other_fault, ramp_done, st} = 8'h80;
    sel = '{`DCS_SEL_SAFE_STOP, `DCS_SEL_MISMATCH, `DCS_SEL_ANY_FAULT, `DCS_SEL_NO_FAULT, 6'h00};
    wt(10);
    chk("state", `DCS_STATE_SAFE_STOP, state);
    chk("ind", 5'h00, ind);
    rst = 1'b0;
    dcs_relay_i.pulse_start();
    dcs_relay_i.set_ch(1'b1, 1'b0, 2);
    wt(20);
    chk("run", 5'h00, run);
    chk("active", 5'h01, ss);
    dcs_relay_i.restart(40);
    wt(2);
    chk("fault", 5'h00, mis);
    chk("run", 5'h01, run);
    chk("state", `DCS_STATE_RUN, state);
    chk("ind", 5'h08, ind);
    dcs_relay_i.set_ch(1'b0, 1'b1, 1);
    wt(6);
    chk("run", 5'h00, run);
    chk("active", 5'h01, ss);
    dcs_relay_i.set_ch(1'b1, 1'b1, 1);
    wt(6);
    chk("run", 5'h00, run);
    for (int i = 0; i < 4; i++) begin
      st = 4'h8 >> i;
      wt(2);
      exp_st = (i == 0) ? `DCS_STATE_UNDERV : 4'(`DCS_STATE_TUNING + i - 1);
      chk("state", 5'(exp_st), state);
    end
    st = 4'h0;
    dcs_relay_i.pulse_start();
    wt(2);
    chk("run", 5'h01, run);
    fork
      dcs_relay_i.ramp_stop();
      begin
        wt(3);
        chk("run", 5'h00, run);
        chk("ramp", 5'h01, ramp);
        ramp_done = 1'b1;
        wt(2);
        chk("ramp", 5'h00, ramp);
        ramp_done = 1'b0;
      end
    join
    wt(4);
    chk("ind", 5'h09, ind);
    other_fault = 1'b1;
    wt(2);
    chk("state", `DCS_STATE_FAULT, state);
    chk("ind", 5'h05, ind);
    dcs_relay_i.restart(10);
    wt(2);
    chk("run", 5'h00, run);
    other_fault = 1'b0;
    dcs_relay_i.pulse_start();
    wt(2);
    chk("run", 5'h01, run);
    results();
  end
endmodule : testbench
